// *** core/tmr_pkg.sv ***
// Package with the register map, field layout and state types of the 8-bit timer
package tmr_pkg;
  localparam int TMR_ADDR_W = 5;
  localparam logic [TMR_ADDR_W-1:0] TMR_OFS_CONTROL = 5'h00;
  localparam logic [TMR_ADDR_W-1:0] TMR_OFS_COUNT = 5'h04;
  localparam logic [TMR_ADDR_W-1:0] TMR_OFS_COMPARE = 5'h08;
  localparam logic [TMR_ADDR_W-1:0] TMR_OFS_FLAG = 5'h0C;
  localparam logic [TMR_ADDR_W-1:0] TMR_OFS_MASK = 5'h10;

  // Control register fields
  localparam int TMR_CS_LSB = 0;
  localparam int TMR_WGM_LSB = 3;
  localparam int TMR_COM_LSB = 5;
  localparam int TMR_FOC_BIT = 7;
  // Flag and mask register fields
  localparam int TMR_OVF_BIT = 0;
  localparam int TMR_CMP_BIT = 1;

  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  localparam logic [7:0] TMR_MAX = 8'hFF;
  localparam logic [7:0] TMR_COUNT_RST = 8'h00;
  localparam logic [9:0] TMR_PSC_RST = 10'h000;

  // Prescaler taps as powers of two
  localparam int TMR_PSC_8 = 3;
  localparam int TMR_PSC_64 = 6;
  localparam int TMR_PSC_256 = 8;
  localparam int TMR_PSC_1024 = 10;

  typedef enum logic [1:0] {
    TMR_WGM_NORMAL = 2'b00,
    TMR_WGM_PHASE_PWM = 2'b01,
    TMR_WGM_CLEAR_ON_MATCH = 2'b10,
    TMR_WGM_FAST_PWM = 2'b11
  } tmr_wgm_t;

  typedef enum logic [2:0] {
    TMR_CS_STOP = 3'b000,
    TMR_CS_DIV1 = 3'b001,
    TMR_CS_DIV8 = 3'b010,
    TMR_CS_DIV64 = 3'b011,
    TMR_CS_DIV256 = 3'b100,
    TMR_CS_DIV1024 = 3'b101,
    TMR_CS_EXT_FALL = 3'b110,
    TMR_CS_EXT_RISE = 3'b111
  } tmr_cs_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [TMR_ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tmr_avm_req_t;

  typedef struct packed {
    logic [7:0] count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    tmr_cs_t clock_select_field;
    tmr_wgm_t waveform_mode_field;
    logic [1:0] compare_output_mode;
    logic overflow_irq_enable;
    logic compare_irq_enable;
    logic overflow_flag;
    logic compare_flag;
    logic compare_output;
    logic count_down;
    logic match_block;
    logic [9:0] prescaler;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic waitrequest;
    logic [31:0] readdata;
    logic overflow_irq;
    logic compare_irq;
  } tmr_state_t;

  localparam tmr_state_t TMR_STATE_RST = '{
    clock_select_field: TMR_CS_STOP,
    waveform_mode_field: TMR_WGM_NORMAL,
    waitrequest: 1'b1,
    default: '0
  };
endpackage

// *** core/tmr_timer8.sv ***
// 8-bit timer with one compare unit, PWM and an Avalon-MM register slave
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module tmr_timer8 (
  input wire logic clk, // 50 MHz system clock
  input wire logic srst, // Synchronous reset, active high
  input wire tmr_pkg::tmr_avm_req_t avm_req, // Avalon-MM request group
  output logic avm_waitrequest, // Avalon-MM waitrequest
  output logic [31:0] avm_readdata, // Avalon-MM read data
  input wire logic external_count_pin, // Asynchronous external count input
  input wire logic global_irq_enable, // Global interrupt flag of the CPU
  input wire logic overflow_irq_ack, // Overflow interrupt serviced, pulse
  input wire logic compare_irq_ack, // Compare interrupt serviced, pulse
  output logic overflow_irq, // Overflow interrupt request
  output logic compare_irq, // Compare interrupt request
  output logic compare_output // Internal compare output state
);
  tmr_pkg::tmr_state_t s_q;
  tmr_pkg::tmr_state_t s_d;
  logic timer_tick;
  logic cpu_access;
  logic cpu_write;
  logic wr_lane0;
  logic pwm_mode;
  logic match;
  logic at_top;
  logic at_bottom;
  logic do_match;
  logic force_hit;
  logic set_ovf;
  logic set_cmp;
  logic clr_ovf;
  logic clr_cmp;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  assign avm_waitrequest = s_q.waitrequest;
  assign avm_readdata = s_q.readdata;
  assign overflow_irq = s_q.overflow_irq;
  assign compare_irq = s_q.compare_irq;
  assign compare_output = s_q.compare_output;

  always_comb
  begin
    s_d = s_q;
    timer_tick = 1'b0;
    rbyte = 8'h00;
    set_ovf = 1'b0;
    set_cmp = 1'b0;
    do_match = 1'b0;
    force_hit = 1'b0;
    // Only lane 0 carries a register; upper lanes are ignored
    wbyte = avm_req.writedata[7:0];
    // Request taken on the cycle that waitrequest is already low
    cpu_access = (avm_req.read | avm_req.write) & ~s_q.waitrequest;
    cpu_write = cpu_access & avm_req.write;
    wr_lane0 = cpu_write & avm_req.byteenable[0];
    pwm_mode = (s_q.waveform_mode_field == tmr_pkg::TMR_WGM_PHASE_PWM) |
               (s_q.waveform_mode_field == tmr_pkg::TMR_WGM_FAST_PWM);
    match = (s_q.count_value == s_q.compare_value);
    at_top = (s_q.count_value == tmr_pkg::TMR_MAX);
    at_bottom = (s_q.count_value == tmr_pkg::TMR_BOTTOM);

    // Prescaler and external pin synchroniser
    // One free-running prescaler serves every divided rate
    s_d.prescaler = s_q.prescaler + 10'h001;
    s_d.ext_s1 = external_count_pin;
    s_d.ext_s2 = s_q.ext_s1;
    // Third flop feeds only the edge detector; a pin edge costs three clocks
    s_d.ext_s3 = s_q.ext_s2;
    // Clock select forms the single tick enable
    case (s_q.clock_select_field)
      tmr_pkg::TMR_CS_STOP: timer_tick = 1'b0;
      tmr_pkg::TMR_CS_DIV1: timer_tick = 1'b1;
      tmr_pkg::TMR_CS_DIV8: timer_tick = &s_q.prescaler[tmr_pkg::TMR_PSC_8-1:0];
      tmr_pkg::TMR_CS_DIV64: timer_tick = &s_q.prescaler[tmr_pkg::TMR_PSC_64-1:0];
      tmr_pkg::TMR_CS_DIV256: timer_tick = &s_q.prescaler[tmr_pkg::TMR_PSC_256-1:0];
      tmr_pkg::TMR_CS_DIV1024: timer_tick = &s_q.prescaler[tmr_pkg::TMR_PSC_1024-1:0];
      tmr_pkg::TMR_CS_EXT_FALL: timer_tick = s_q.ext_s3 & ~s_q.ext_s2;
      tmr_pkg::TMR_CS_EXT_RISE: timer_tick = s_q.ext_s2 & ~s_q.ext_s3;
      default: timer_tick = 1'b0;
    endcase

    // Counter and waveform advance one step per tick
    if (timer_tick)
    begin
      // A blocked match is dropped for this tick only
      // The block waits for a tick, so a stopped timer keeps it armed
      do_match = match & ~s_q.match_block;
      set_cmp = do_match;
      s_d.match_block = 1'b0;
      case (s_q.waveform_mode_field)
        tmr_pkg::TMR_WGM_NORMAL:
        begin
          s_d.count_value = s_q.count_value + 8'h01;
          set_ovf = at_top;
          if (do_match)
          begin
            case (s_q.compare_output_mode)
              2'b01: s_d.compare_output = ~s_q.compare_output;
              2'b10: s_d.compare_output = 1'b0;
              2'b11: s_d.compare_output = 1'b1;
              default: s_d.compare_output = s_q.compare_output;
            endcase
          end
        end
        tmr_pkg::TMR_WGM_CLEAR_ON_MATCH:
        begin
          if (do_match)
          begin
            s_d.count_value = tmr_pkg::TMR_BOTTOM;
            case (s_q.compare_output_mode)
              2'b01: s_d.compare_output = ~s_q.compare_output;
              2'b10: s_d.compare_output = 1'b0;
              2'b11: s_d.compare_output = 1'b1;
              default: s_d.compare_output = s_q.compare_output;
            endcase
          end
          else
          begin
            s_d.count_value = s_q.count_value + 8'h01;
          end
          // Overflow only when the count really wraps past max
          set_ovf = at_top & ~do_match;
        end
        tmr_pkg::TMR_WGM_FAST_PWM:
        begin
          s_d.count_value = s_q.count_value + 8'h01;
          // Overflow when the count reaches max
          set_ovf = (s_q.count_value == (tmr_pkg::TMR_MAX - 8'h01));
          if (do_match)
          begin
            if (s_q.compare_output_mode == 2'b10)
            begin
              s_d.compare_output = 1'b0;
            end
            else if (s_q.compare_output_mode == 2'b11)
            begin
              s_d.compare_output = 1'b1;
            end
          end
          // Output mode 1 has no waveform action here
          // Wrap to bottom overrides a match on the same tick
          if (at_top)
          begin
            s_d.compare_value = s_q.compare_buffer;
            if (s_q.compare_output_mode == 2'b10)
            begin
              s_d.compare_output = 1'b1;
            end
            else if (s_q.compare_output_mode == 2'b11)
            begin
              s_d.compare_output = 1'b0;
            end
          end
        end
        default:
        begin
          // Phase correct: turn at max and at bottom
          // Direction survives count writes and mode changes
          if (s_q.count_down)
          begin
            if (at_bottom)
            begin
              s_d.count_down = 1'b0;
              s_d.count_value = s_q.count_value + 8'h01;
            end
            else
            begin
              s_d.count_value = s_q.count_value - 8'h01;
            end
          end
          else if (at_top)
          begin
            s_d.count_down = 1'b1;
            s_d.count_value = s_q.count_value - 8'h01;
            s_d.compare_value = s_q.compare_buffer;
          end
          else
          begin
            s_d.count_value = s_q.count_value + 8'h01;
          end
          set_ovf = s_q.count_down & at_bottom;
          if (do_match)
          begin
            if (s_q.compare_output_mode == 2'b10)
            begin
              s_d.compare_output = s_q.count_down;
            end
            else if (s_q.compare_output_mode == 2'b11)
            begin
              s_d.compare_output = ~s_q.count_down;
            end
          end
        end
      endcase
    end

    // Register reads, answered one cycle after the request is seen
    // Unmapped offsets read zero and drop writes
    if (avm_req.address == tmr_pkg::TMR_OFS_CONTROL)
    begin
      rbyte = {1'b0, s_q.compare_output_mode, s_q.waveform_mode_field,
               s_q.clock_select_field};
    end
    else if (avm_req.address == tmr_pkg::TMR_OFS_COUNT)
    begin
      rbyte = s_q.count_value;
    end
    else if (avm_req.address == tmr_pkg::TMR_OFS_COMPARE)
    begin
      // Buffer readback in PWM modes shows software its own last write
      rbyte = pwm_mode ? s_q.compare_buffer : s_q.compare_value;
    end
    else if (avm_req.address == tmr_pkg::TMR_OFS_FLAG)
    begin
      rbyte = {6'h00, s_q.compare_flag, s_q.overflow_flag};
    end
    else if (avm_req.address == tmr_pkg::TMR_OFS_MASK)
    begin
      rbyte = {6'h00, s_q.compare_irq_enable, s_q.overflow_irq_enable};
    end
    // One wait state per request: seen on one edge, answered on the next
    s_d.waitrequest = ~((avm_req.read | avm_req.write) & s_q.waitrequest);
    if (avm_req.read & s_q.waitrequest)
    begin
      s_d.readdata = {24'h000000, rbyte};
    end
    else
    begin
      // Idle bus reads zero so stale data never lingers
      s_d.readdata = 32'h00000000;
    end

    // Register writes
    clr_ovf = 1'b0;
    clr_cmp = 1'b0;
    if (wr_lane0)
    begin
      if (avm_req.address == tmr_pkg::TMR_OFS_CONTROL)
      begin
        s_d.clock_select_field = tmr_pkg::tmr_cs_t'(wbyte[tmr_pkg::TMR_CS_LSB +: 3]);
        // Output state untouched by a mode change
        s_d.waveform_mode_field = tmr_pkg::tmr_wgm_t'(wbyte[tmr_pkg::TMR_WGM_LSB +: 2]);
        s_d.compare_output_mode = wbyte[tmr_pkg::TMR_COM_LSB +: 2];
        // Force acts with the output mode written alongside it
        force_hit = wbyte[tmr_pkg::TMR_FOC_BIT] & ~pwm_mode;
        if (force_hit)
        begin
          case (wbyte[tmr_pkg::TMR_COM_LSB +: 2])
            2'b01: s_d.compare_output = ~s_q.compare_output;
            2'b10: s_d.compare_output = 1'b0;
            2'b11: s_d.compare_output = 1'b1;
            default: s_d.compare_output = s_q.compare_output;
          endcase
        end
      end
      else if (avm_req.address == tmr_pkg::TMR_OFS_COUNT)
      begin
        s_d.count_value = wbyte;
        s_d.match_block = 1'b1;
      end
      else if (avm_req.address == tmr_pkg::TMR_OFS_COMPARE)
      begin
        // Non-PWM writes fill both, so a later PWM switch starts from them
        s_d.compare_buffer = wbyte;
        if (!pwm_mode)
        begin
          s_d.compare_value = wbyte;
        end
      end
      else if (avm_req.address == tmr_pkg::TMR_OFS_FLAG)
      begin
        clr_ovf = wbyte[tmr_pkg::TMR_OVF_BIT];
        clr_cmp = wbyte[tmr_pkg::TMR_CMP_BIT];
      end
      else if (avm_req.address == tmr_pkg::TMR_OFS_MASK)
      begin
        s_d.overflow_irq_enable = wbyte[tmr_pkg::TMR_OVF_BIT];
        s_d.compare_irq_enable = wbyte[tmr_pkg::TMR_CMP_BIT];
      end
    end

    // Hardware set wins over any clear in the same cycle
    if (set_ovf)
    begin
      s_d.overflow_flag = 1'b1;
    end
    else if (clr_ovf | overflow_irq_ack)
    begin
      s_d.overflow_flag = 1'b0;
    end
    if (set_cmp)
    begin
      s_d.compare_flag = 1'b1;
    end
    else if (clr_cmp | compare_irq_ack)
    begin
      s_d.compare_flag = 1'b0;
    end
    // Requests follow next-state flags, so they never lag a clear
    s_d.overflow_irq = s_d.overflow_flag & s_d.overflow_irq_enable & global_irq_enable;
    s_d.compare_irq = s_d.compare_flag & s_d.compare_irq_enable & global_irq_enable;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= tmr_pkg::TMR_STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// *** tb/tmr_timer8_checker.sv ***
// Port-level assertions for the 8-bit timer
`timescale 1ns/1ps
module tmr_timer8_checker (
  input wire logic clk, // Clock
  input wire logic srst, // Synchronous reset
  input wire tmr_pkg::tmr_avm_req_t avm_req, // Bus request group
  input wire logic avm_waitrequest, // Bus wait
  input wire logic [31:0] avm_readdata, // Bus read data
  input wire logic external_count_pin, // External count input
  input wire logic global_irq_enable, // Global interrupt flag
  input wire logic overflow_irq_ack, // Overflow serviced
  input wire logic compare_irq_ack, // Compare serviced
  input wire logic overflow_irq, // Overflow request
  input wire logic compare_irq, // Compare request
  input wire logic compare_output // Output state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_req_seen;
    (avm_req.read || avm_req.write) && avm_waitrequest;
  endsequence
  sequence s_answer;
    !avm_waitrequest ##1 avm_waitrequest;
  endsequence
  a_req_answer: assert property (s_req_seen |=> s_answer)
    else $error("bus request not answered after one wait cycle");
  a_no_spurious: assert property (!avm_waitrequest |-> $past(avm_req.read || avm_req.write))
    else $error("waitrequest low without a request");
  a_rdata_idle: assert property (avm_waitrequest |-> avm_readdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_rdata_width: assert property (avm_readdata[31:8] == 24'h0)
    else $error("read data wider than eight bits");
  a_reset_vals: assert property ($past(srst) |-> avm_waitrequest && !compare_output
    && !overflow_irq && !compare_irq)
    else $error("outputs not cleared by reset");
  a_cmp_irq_gate: assert property (!global_irq_enable |=> !compare_irq)
    else $error("compare request without global enable");
  a_ovf_irq_gate: assert property (!global_irq_enable |=> !overflow_irq)
    else $error("overflow request without global enable");
  a_ack_drop: assert property (compare_irq && compare_irq_ack && global_irq_enable
    |=> !compare_irq)
    else $error("compare request stays after service");
endmodule

bind tmr_timer8 tmr_timer8_checker chk_i (.clk(clk), .srst(srst), .avm_req(avm_req),
  .avm_waitrequest(avm_waitrequest), .avm_readdata(avm_readdata),
  .external_count_pin(external_count_pin), .global_irq_enable(global_irq_enable),
  .overflow_irq_ack(overflow_irq_ack), .compare_irq_ack(compare_irq_ack),
  .overflow_irq(overflow_irq), .compare_irq(compare_irq), .compare_output(compare_output));

// *** tb/test_tmr_timer8.sv ***
// Self-checking testbench for the 8-bit timer
`timescale 1ns/1ps
module test_tmr_timer8;
  localparam logic [4:0] CTL = tmr_pkg::TMR_OFS_CONTROL;
  localparam logic [4:0] CNT = tmr_pkg::TMR_OFS_COUNT;
  localparam logic [4:0] CMP = tmr_pkg::TMR_OFS_COMPARE;
  localparam logic [4:0] FLG = tmr_pkg::TMR_OFS_FLAG;
  localparam logic [4:0] MSK = tmr_pkg::TMR_OFS_MASK;
  logic clk, srst, ext_pin, gie, ovf_ack, cmp_ack;
  logic wait_req, ovf_irq, cmp_irq, cmp_out;
  logic [31:0] rdata;
  tmr_pkg::tmr_avm_req_t req;
  int err_count, n_checks;
  tmr_timer8 uut (.clk(clk), .srst(srst), .avm_req(req), .avm_waitrequest(wait_req),
    .avm_readdata(rdata), .external_count_pin(ext_pin), .global_irq_enable(gie),
    .overflow_irq_ack(ovf_ack), .compare_irq_ack(cmp_ack), .overflow_irq(ovf_irq),
    .compare_irq(cmp_irq), .compare_output(cmp_out));
  always #10 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk);
    req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}, byteenable: 4'hF};
    @(posedge clk);
    // Only the watchdog ends a wait that never sees the answer
    while (wait_req !== 1'b0)
    begin
      @(posedge clk);
    end
    q = rdata[7:0];
    req <= '0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask
  // Let the completing edge land before looking at registered outputs
  task automatic pin_chk(input string nm, input logic e, ref logic g);
    repeat (2) @(posedge clk);
    chk(nm, {7'h0, e}, {7'h0, g});
  endtask
  // Pulses are wide enough for the two-flop synchroniser
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic pulse(input logic on_cmp);
    @(posedge clk);
    if (on_cmp)
      cmp_ack <= 1'b1;
    else
      ovf_ack <= 1'b1;
    @(posedge clk);
    cmp_ack <= 1'b0;
    ovf_ack <= 1'b0;
  endtask
  task automatic t_reset;
    rd_chk("control", CTL, 8'h00);
    rd_chk("count", CNT, 8'h00);
    rd_chk("compare", CMP, 8'h00);
    rd_chk("flags", FLG, 8'h00);
    rd_chk("mask", MSK, 8'h00);
    wr(5'h14, 8'hFF);
    rd_chk("unmapped", 5'h14, 8'h00);
  endtask
  task automatic t_stop;
    wr(CNT, 8'h10);
    tick(2);
    rd_chk("count", CNT, 8'h10);
  endtask
  task automatic t_normal;
    wr(CTL, 8'h27);
    wr(CMP, 8'hFF);
    wr(CNT, 8'hFE);
    tick(1);
    rd_chk("count", CNT, 8'hFF);
    rd_chk("flags", FLG, 8'h00);
    tick(1);
    rd_chk("count", CNT, 8'h00);
    rd_chk("flags", FLG, 8'h03);
    pin_chk("compare_output", 1'b1, cmp_out);
  endtask
  task automatic t_irq;
    wr(MSK, 8'h03);
    gie <= 1'b1;
    pin_chk("overflow_irq", 1'b1, ovf_irq);
    pin_chk("compare_irq", 1'b1, cmp_irq);
    wr(MSK, 8'h01);
    pin_chk("compare_irq", 1'b0, cmp_irq);
    wr(MSK, 8'h03);
    gie <= 1'b0;
    pin_chk("compare_irq", 1'b0, cmp_irq);
    gie <= 1'b1;
    wr(FLG, 8'h02);
    rd_chk("flags", FLG, 8'h01);
    pulse(1'b0);
    rd_chk("flags", FLG, 8'h00);
  endtask
  task automatic t_block;
    wr(CTL, 8'h00);
    wr(CMP, 8'h20);
    wr(CNT, 8'h20);
    wr(CTL, 8'h07);
    tick(1);
    rd_chk("flags", FLG, 8'h00);
    rd_chk("count", CNT, 8'h21);
  endtask
  task automatic t_ctc;
    wr(CTL, 8'h37);
    wr(CMP, 8'h02);
    wr(CNT, 8'h00);
    tick(3);
    rd_chk("count", CNT, 8'h00);
    rd_chk("flags", FLG, 8'h02);
    pin_chk("compare_output", 1'b0, cmp_out);
    pin_chk("compare_irq", 1'b1, cmp_irq);
    pulse(1'b1);
    rd_chk("flags", FLG, 8'h00);
  endtask
  task automatic t_force;
    wr(CTL, 8'hE0);
    pin_chk("compare_output", 1'b1, cmp_out);
    wr(CTL, 8'hC0);
    pin_chk("compare_output", 1'b0, cmp_out);
    wr(CTL, 8'hA0);
    pin_chk("compare_output", 1'b1, cmp_out);
    wr(CTL, 8'h80);
    pin_chk("compare_output", 1'b1, cmp_out);
    rd_chk("flags", FLG, 8'h00);
    rd_chk("count", CNT, 8'h00);
    rd_chk("control", CTL, 8'h00);
  endtask
  task automatic t_pwm;
    wr(CMP, 8'h10);
    wr(CNT, 8'h0F);
    wr(CTL, 8'h5F);
    pin_chk("compare_output", 1'b1, cmp_out);
    wr(CMP, 8'h30);
    rd_chk("compare", CMP, 8'h30);
    tick(2);
    pin_chk("compare_output", 1'b0, cmp_out);
    wr(CNT, 8'hFE);
    tick(1);
    rd_chk("flags", FLG, 8'h03);
    tick(1);
    pin_chk("compare_output", 1'b1, cmp_out);
    wr(CTL, 8'h00);
    rd_chk("compare", CMP, 8'h30);
    pin_chk("compare_output", 1'b1, cmp_out);
  endtask
  // Windows of 64 clocks hold a whole number of divided ticks
  task automatic t_clk;
    wr(CNT, 8'h00);
    wr(CTL, 8'h01);
    wr(CTL, 8'h00);
    rd_chk("count", CNT, 8'h03);
    wr(CTL, 8'h02);
    repeat (61) @(posedge clk);
    wr(CTL, 8'h00);
    rd_chk("count", CNT, 8'h0B);
    wr(CTL, 8'h03);
    repeat (61) @(posedge clk);
    wr(CTL, 8'h00);
    rd_chk("count", CNT, 8'h0C);
    wr(CTL, 8'h06);
    tick(1);
    rd_chk("count", CNT, 8'h0D);
  endtask
  task automatic t_phase;
    wr(CMP, 8'hF0);
    wr(CNT, 8'hEF);
    wr(CTL, 8'h4F);
    tick(2);
    pin_chk("compare_output", 1'b0, cmp_out);
    wr(CNT, 8'hFE);
    tick(2);
    rd_chk("count", CNT, 8'hFE);
    wr(CNT, 8'hF1);
    tick(2);
    pin_chk("compare_output", 1'b1, cmp_out);
    wr(FLG, 8'h03);
    wr(CNT, 8'h01);
    tick(2);
    rd_chk("flags", FLG, 8'h01);
    rd_chk("count", CNT, 8'h01);
  endtask
  task automatic wrap_up;
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    req = '0;
    ext_pin = 1'b0;
    gie = 1'b0;
    ovf_ack = 1'b0;
    cmp_ack = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_stop;
    t_normal;
    t_irq;
    t_block;
    t_ctc;
    t_force;
    t_pwm;
    t_clk;
    t_phase;
    wrap_up;
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up;
  end
endmodule
